/* File: bench/rx_segmented_local_bus_chk.sv */
// concurrent checks on the receive segment bus and its reset ports
`timescale 1ns/100ps
`include "segmented_local_bus_cfg.svh"
module rx_segmented_local_bus_chk
#(
    parameter int PW = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`SEGS-1:0] rx_seg_valid,
    input wire logic [`SEGS-1:0] rx_seg_first,
    input wire logic [`SEGS-1:0] rx_seg_last,
    input wire logic [`SEGS-1:0] rx_seg_bad,
    input wire logic [`SEGS-1:0][`EMPTY_W-1:0] rx_seg_empty_bytes,
    input wire logic rx_reset_done,
    input wire logic usr_rx_rst,
    input wire logic [`SERDES_LANES-1:0] usr_rx_serdes_rst,
    input wire logic [`SERDES_LANES-1:0] rx_serdes_clk,
    input wire logic regmap_xcvr_full_rst,
    input wire logic [PW-1:0] pll_a_rst_out,
    input wire logic [PW-1:0] pll_b_rst_out
);
    logic [1:0] up;
    logic stray;
    logic bad_nz;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // edges since reset release, so the lane toggle check skips start-up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;
    end
    // empty count seen where it has no meaning, or not cleared on error
    always_comb
    begin
        stray = 1'b0;
        bad_nz = 1'b0;
        for (int s = 0; s < `SEGS; s++)
        begin
            if (!(rx_seg_valid[s] && rx_seg_last[s]))
                stray = stray | (rx_seg_empty_bytes[s] != 4'h0);
            if (rx_seg_valid[s] && rx_seg_bad[s])
                bad_nz = bad_nz | (rx_seg_empty_bytes[s][2:0] != 3'h0);
        end
    end
    a_first_needs_valid: assert property (
        !(rx_seg_first & ~rx_seg_valid))
        else $error("first flag on idle segment");
    a_last_needs_valid: assert property (!(rx_seg_last & ~rx_seg_valid))
        else $error("last flag on idle segment");
    a_bad_needs_last: assert property (!(rx_seg_bad & ~rx_seg_last))
        else $error("bad flag without last flag");
    a_empty_needs_last: assert property (!stray)
        else $error("empty count outside a last transfer");
    a_empty_bad_low: assert property (!bad_nz)
        else $error("empty low bits set on bad packet");
    a_valid_held_done: assert property (
        (!rx_reset_done)[*5] |-> !rx_seg_valid)
        else $error("segment enabled before reset done");
    a_valid_held_rst: assert property (usr_rx_rst[*3] |-> !rx_seg_valid)
        else $error("segment enabled during rx reset");
    a_lane_clk_held: assert property (
        !(usr_rx_serdes_rst & rx_serdes_clk & $past(usr_rx_serdes_rst)))
        else $error("lane clock runs in serdes reset");
    a_lane_clk_runs: assert property (
        up == 2'h3 |-> !(~usr_rx_serdes_rst & ~$past(usr_rx_serdes_rst)
        & ~(rx_serdes_clk ^ $past(rx_serdes_clk))))
        else $error("lane clock stopped out of reset");
    a_pll_rst_sel: assert property (
        pll_a_rst_out == {PW{regmap_xcvr_full_rst}} && pll_b_rst_out == '0)
        else $error("pll reset not following full reset");
endmodule : rx_segmented_local_bus_chk

/* File: bench/tb_top.sv */
// self-checking bench for the receive segment bus pair
`timescale 1ns/100ps
`include "segmented_local_bus_cfg.svh"
module tb_top import segmented_local_bus_pkg::*;;
    typedef struct packed {
        logic [3:0] v;
        logic [3:0] f;
        logic [3:0] l;
        logic [3:0] b;
        logic [15:0] e;
        logic [2:0] ends;
        logic [2:0] bends;
        logic [15:0] len;
    } row_t;
    // source segments in, bus flags and packet tally out
    localparam row_t rows [8] = '{
        '{4'h1, 4'h1, 4'h0, 4'h0, 16'h0000, 3'h0, 3'h0, 16'h0000},
        '{4'h1, 4'h0, 4'h1, 4'h0, 16'h0003, 3'h1, 3'h0, 16'h001d},
        '{4'hf, 4'h1, 4'h8, 4'h0, 16'h5000, 3'h1, 3'h0, 16'h003b},
        '{4'hf, 4'h7, 4'hb, 4'h0, 16'h0020, 3'h3, 3'h0, 16'h0020},
        '{4'h3, 4'h1, 4'h2, 4'h2, 16'h00f0, 3'h1, 3'h1, 16'h0000},
        '{4'h0, 4'hf, 4'hf, 4'hf, 16'hffff, 3'h0, 3'h0, 16'h0000},
        '{4'h1, 4'h1, 4'h0, 4'h1, 16'h0007, 3'h0, 3'h0, 16'h0000},
        '{4'h1, 4'h0, 4'h1, 4'h0, 16'h0000, 3'h1, 3'h0, 16'h0020}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] src_valid, src_first, src_last, src_bad, rst_req;
    seg_data_t src_data;
    seg_empty_t src_empty;
    logic xtx, xrx, wtx, wrx, framing_err, err;
    logic [9:0] wsd, pat, serdes_rst_req;
    logic [2:0] pkt_ends, pkt_bad_ends, lk;
    logic [15:0] pkt_last_len;
    int errors = 0;
    int compares = 0;
    rx_segmented_local_bus_if #(.LANES(10)) bus ();
    rx_segmented_local_bus_core #(.LANES(10)) rx_segmented_local_bus_core_inst (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .src_valid(src_valid),
        .src_data(src_data), .src_first(src_first), .src_last(src_last),
        .src_bad(src_bad), .src_empty(src_empty), .xcvr_tx_done_raw(xtx),
        .xcvr_rx_done_raw(xrx), .bus(bus));
    rx_segmented_local_bus_user #(.LANES(10)) rx_segmented_local_bus_user_inst (.pclk(pclk),
        .presetn(presetn), .wrap_tx_done(wtx), .wrap_rx_done(wrx),
        .wrap_serdes_done(wsd), .ext_serdes_clk(pat ^ 10'h0ff),
        .ext_pll_a_clk(pat), .ext_pll_a_ref_clk(~pat),
        .ext_pll_b_clk({pat[4:0], pat[9:5]}),
        .ext_pll_b_ref_clk(pat ^ 10'h155), .ext_pll_a_lock(lk),
        .ext_pll_b_lock(lk), .pkt_ends(pkt_ends),
        .pkt_bad_ends(pkt_bad_ends), .pkt_last_len(pkt_last_len),
        .framing_err(framing_err), .rst_req(rst_req),
        .serdes_rst_req(serdes_rst_req), .bus(bus));
    rx_segmented_local_bus_chk #(.PW(3)) rx_segmented_local_bus_chk_inst (.pclk(pclk), .presetn(presetn),
        .rx_seg_valid(bus.rx_seg_valid), .rx_seg_first(bus.rx_seg_first),
        .rx_seg_last(bus.rx_seg_last), .rx_seg_bad(bus.rx_seg_bad),
        .rx_seg_empty_bytes(bus.rx_seg_empty_bytes),
        .rx_reset_done(bus.rx_reset_done), .usr_rx_rst(bus.usr_rx_rst),
        .usr_rx_serdes_rst(bus.usr_rx_serdes_rst),
        .rx_serdes_clk(bus.rx_serdes_clk),
        .regmap_xcvr_full_rst(bus.regmap_xcvr_full_rst),
        .pll_a_rst_out(bus.pll_a_rst_out), .pll_b_rst_out(bus.pll_b_rst_out));
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rdat = prdata;
        err = pslverr;
        errors += (n >= 40);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk({err, rdat}, {1'b0, e});
    endtask : rd_chk
    // one row: bus outputs one edge later, user tally one more edge later
    task automatic drive_row(input row_t r, input int i);
        logic [3:0] vl;
        logic [3:0] ee;
        vl = r.v & r.l;
        for (int s = 0; s < 4; s++)
            src_data[s] <= {16{8'(i * 4 + s)}};
        {src_valid, src_first, src_last, src_bad} <= {r.v, r.f, r.l, r.b};
        src_empty <= r.e;
        @(posedge pclk);
        src_valid <= 4'h0;
        @(posedge pclk);
        chk({bus.rx_seg_valid, bus.rx_seg_first}, {r.v, r.f & r.v});
        chk({bus.rx_seg_last, bus.rx_seg_bad}, {vl, r.b & vl});
        for (int s = 0; s < 4; s++)
        begin
            ee = vl[s] ? r.e[4*s+:4] : 4'h0;
            ee[2:0] = (r.b[s] & vl[s]) ? 3'h0 : ee[2:0];
            chk(bus.rx_seg_empty_bytes[s], ee);
            if (r.v[s])
                chk(bus.rx_seg_data[s], {16{8'(i * 4 + s)}});
        end
        @(posedge pclk);
        chk({pkt_ends, pkt_bad_ends}, {r.ends, r.bends});
        if (r.ends != 3'h0 && r.bends == 3'h0)
            chk(pkt_last_len, r.len);
    endtask : drive_row
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #(25 * 5000);
        errors++;
        end_sim();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {src_valid, src_first, src_last, src_bad, src_data, src_empty} = '0;
        {xtx, xrx, wtx, wrx, wsd, pat} = '0;
        lk = 3'h5;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({pready, pslverr, irq, bus.rx_seg_valid, rst_req}, 0);
        rd_chk(8'h10, 32'h0);
        src_valid <= 4'hf;
        repeat (3) @(posedge pclk);
        chk(bus.rx_seg_valid, 4'h0);
        {src_valid, xtx, xrx, wtx, wrx, wsd} <= {4'h0, 4'hf, 10'h3ff};
        for (int n = 0; n < 20 && rdat[4] !== 1'b1; n++)
            apb(1'b0, 8'h08, 32'h0);
        chk(rdat, 32'h000bffff);
        chk({bus.xcvr_tx_rst_complete, bus.xcvr_rx_rst_complete}, 2'h3);
        chk({bus.tx_reset_done_sync, bus.rx_reset_done_sync}, 2'h3);
        chk(bus.rx_serdes_reset_done, 10'h3ff);
        rd_chk(8'h0c, 32'h4);
        apb(1'b1, 8'h0c, 32'h7);
        foreach (rows[i])
            drive_row(rows[i], i);
        chk(framing_err, 1'b0);
        rd_chk(8'h14, 32'h7);
        apb(1'b1, 8'h10, 32'h1);
        drive_row(rows[3], 3);
        chk(irq, 1'b1);
        apb(1'b1, 8'h0c, 32'h1);
        chk(irq, 1'b0);
        apb(1'b1, 8'h10, 32'h0);
        drive_row(rows[4], 4);
        chk(irq, 1'b0);
        rd_chk(8'h0c, 32'h3);
        apb(1'b1, 8'h10, 32'h2);
        chk(irq, 1'b1);
        apb(1'b1, 8'h0c, 32'h3);
        chk(irq, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, 8'h00, 32'h1 << k);
            @(posedge pclk);
            chk({bus.regmap_xcvr_loopback, bus.regmap_xcvr_full_rst,
                bus.usr_rx_rst, bus.usr_tx_rst, rst_req}, 8'h11 << k);
            rd_chk(8'h00, 32'h1 << k);
            // whole packets per segment, so no framing error is left behind
            {src_valid, src_first, src_last} <= 12'hfff;
            repeat (3) @(posedge pclk);
            src_valid <= 4'h0;
            chk(bus.rx_seg_valid, (k == 1) ? 4'h0 : 4'hf);
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h2a5);
        repeat (2) @(posedge pclk);
        chk({bus.usr_rx_serdes_rst, serdes_rst_req}, 20'ha96a5);
        chk(bus.rx_serdes_clk & 10'h2a5, 10'h0);
        rd_chk(8'h04, 32'h2a5);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({err, rdat}, 33'h100000000);
        for (int k = 0; k < 2; k++)
        begin
            pat <= k[0] ? 10'h30f : 10'h0f0;
            repeat (2) @(posedge pclk);
            chk({bus.pll_a_clk, bus.pll_a_ref_clk, bus.pll_b_clk}, {pat, ~pat,
                pat[4:0], pat[9:5]});
            chk({bus.pll_b_ref_clk, bus.rx_serdes_clk_in},
                {pat ^ 10'h155, pat ^ 10'h0ff});
        end
        chk(framing_err, 1'b0);
        drive_row(rows[0], 0);
        drive_row(rows[0], 0);
        chk(framing_err, 1'b1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({bus.rx_seg_valid, irq, framing_err, bus.usr_rx_rst}, 0);
        end_sim();
    end
endmodule : tb_top

/* File: verilog/rx_segmented_local_bus_core.sv */
// core end: receive segment bus, reset ports and apb register map
`timescale 1ns/100ps
`include "segmented_local_bus_cfg.svh"
module rx_segmented_local_bus_core
    import segmented_local_bus_pkg::*;
#(
    parameter int LANES = 10,
    parameter int PLL_SEL = 0,
    parameter bit SIMPLEX_RX = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    input wire logic [`SEGS-1:0] src_valid,
    input wire seg_data_t src_data,
    input wire logic [`SEGS-1:0] src_first,
    input wire logic [`SEGS-1:0] src_last,
    input wire logic [`SEGS-1:0] src_bad,
    input wire seg_empty_t src_empty,
    input wire logic xcvr_tx_done_raw,
    input wire logic xcvr_rx_done_raw,
    rx_segmented_local_bus_if.dev bus
);
    localparam int PW = (LANES == 10) ? 3 : 1;

    // only the two documented lane counts and two pll kinds exist
    if (!(LANES == 10 || LANES == 4) || !(PLL_SEL == 0 || PLL_SEL == 1))
    begin : bad_cfg
        $error("rx_segmented_local_bus_core: unsupported LANES or PLL_SEL");
    end

    core_state_t s;
    core_state_t next_s;
    pinset_t pins;
    logic [2:0] lock_pad;
    logic ready;
    logic wr;
    logic hit;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [2:0] ends;

    always_comb
    begin
        lock_pad = 3'h0;
        if (PLL_SEL == 0)
            lock_pad[PW-1:0] = bus.pll_a_lock_in;
        else
            lock_pad[PW-1:0] = bus.pll_b_lock_in;
    end

    // wrapper done bits gathered for the crossing
    assign pins.done = {bus.rx_reset_done_sync, bus.tx_reset_done_sync,
                        bus.rx_reset_done, bus.tx_reset_done};
    assign pins.serdes = bus.rx_serdes_reset_done;
    assign pins.lock = lock_pad;
    assign pins.xcvr = {xcvr_rx_done_raw, xcvr_tx_done_raw};

    // simplex receive relies on the synced rx indication
    always_comb
    begin
        if (SIMPLEX_RX)
            ready = s.s2.done[3] && (&s.s2.serdes) && !s.ctrl[`CTRL_RX_RST];
        else
            ready = s.s2.done[0] && s.s2.done[1] && (&s.s2.serdes)
                && !s.ctrl[`CTRL_RX_RST];
    end

    assign wr = psel && penable && s.pready && pwrite;
    assign clr = (wr && paddr == `REG_IRQ_STAT) ? pwdata[2:0] : 3'h0;

    // address hit test; unaligned or unmapped gets pslverr
    always_comb
    begin
        case (paddr)
            `REG_CTRL, `REG_SERDES_RST, `REG_STATUS,
            `REG_IRQ_STAT, `REG_IRQ_MASK, `REG_PKT_COUNT: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // next-state of the whole core
    always_comb
    begin
        next_s = s;
        next_s.s1 = pins;
        next_s.s2 = s.s1;
        next_s.ready_prev = ready;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        ends = 3'h0;
        // transceiver done bits re-timed and forwarded
        next_s.xcvr_tx = s.s2.xcvr[0];
        next_s.xcvr_rx = s.s2.xcvr[1];
        for (int i = 0; i < `SEGS; i++)
        begin
            // enables held low until reset complete
            next_s.valid[i] = src_valid[i] && ready;
            next_s.data[i] = src_data[i];
            next_s.first[i] = next_s.valid[i] && src_first[i];
            next_s.last[i] = next_s.valid[i] && src_last[i];
            // bad only with enable and last
            next_s.bad[i] = next_s.last[i] && src_bad[i];
            // empty count only on the closing transfer
            next_s.empty[i] = next_s.last[i] ? src_empty[i] : 4'h0;
            // bad packet clears the low three bits
            if (next_s.bad[i])
                next_s.empty[i][2:0] = 3'h0;
            ends = ends + {2'h0, next_s.last[i]};
        end
        ev[`IRQ_PKT_END] = |next_s.last;
        ev[`IRQ_PKT_BAD] = |next_s.bad;
        ev[`IRQ_RX_READY] = ready && !s.ready_prev;
        next_s.pkt_count = s.pkt_count + {29'h0, ends};
        // lane clocks stop while their serdes reset is held
        for (int i = 0; i < `SERDES_LANES; i++)
        begin
            next_s.lane_clk[i] = s.serdes_rst[i] ? 1'b0 : !s.lane_clk[i];
        end
        // apb setup cycle: fetch read data, answer in access phase
        if (psel && !penable)
        begin
            next_s.pready = 1'b1;
            next_s.pslverr = !hit;
            case (paddr)
                `REG_CTRL: next_s.prdata = {28'h0, s.ctrl};
                `REG_SERDES_RST: next_s.prdata = {22'h0, s.serdes_rst};
                `REG_STATUS: next_s.prdata = {12'h0, s.s2.lock,
                    s.s2.serdes, s.s2.xcvr, ready, s.s2.done};
                `REG_IRQ_STAT: next_s.prdata = {29'h0, s.irq_stat};
                `REG_IRQ_MASK: next_s.prdata = {29'h0, s.irq_mask};
                `REG_PKT_COUNT: next_s.prdata = s.pkt_count;
                default: next_s.prdata = 32'h0;
            endcase
        end
        if (wr)
        begin
            case (paddr)
                // user resets; full reset and loopback
                `REG_CTRL: next_s.ctrl = pwdata[3:0];
                `REG_SERDES_RST: next_s.serdes_rst = pwdata[9:0];
                `REG_IRQ_MASK: next_s.irq_mask = pwdata[2:0];
                default: next_s.irq_mask = s.irq_mask;
            endcase
        end
        // a new event beats a write-one clear in the same cycle
        next_s.irq_stat = (s.irq_stat & ~clr) | ev;
        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.ctrl <= `CTRL_RESET;
            s.serdes_rst <= `SERDES_RST_RESET;
            s.irq_mask <= `IRQ_MASK_RESET;
        end
        else
            s <= next_s;
    end

    assign pready = s.pready;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign irq = s.irq;

    // every segment flag comes from the qualified copy; rx_seg_data is registered from src_data unqualified
    assign bus.rx_seg_valid = s.valid;
    assign bus.rx_seg_data = s.data;
    assign bus.rx_seg_first = s.first;
    assign bus.rx_seg_last = s.last;
    assign bus.rx_seg_bad = s.bad;
    assign bus.rx_seg_empty_bytes = s.empty;
    assign bus.xcvr_tx_rst_complete = s.xcvr_tx;
    assign bus.xcvr_rx_rst_complete = s.xcvr_rx;
    assign bus.usr_tx_rst = s.ctrl[`CTRL_TX_RST];
    assign bus.usr_rx_rst = s.ctrl[`CTRL_RX_RST];
    assign bus.usr_rx_serdes_rst = s.serdes_rst;
    assign bus.regmap_xcvr_full_rst = s.ctrl[`CTRL_FULL_RST];
    assign bus.regmap_xcvr_loopback = s.ctrl[`CTRL_LOOPBACK];
    assign bus.rx_serdes_clk = s.lane_clk;
    // only the chosen pll gets its reset
    assign bus.pll_a_rst_out = (PLL_SEL == 0) ?
        {PW{s.ctrl[`CTRL_FULL_RST]}} : {PW{1'b0}};
    assign bus.pll_b_rst_out = (PLL_SEL == 1) ?
        {PW{s.ctrl[`CTRL_FULL_RST]}} : {PW{1'b0}};
endmodule : rx_segmented_local_bus_core

/* File: verilog/rx_segmented_local_bus_if.sv */
// interface joining the core end and the user end of the receive bus
`timescale 1ns/100ps
`include "segmented_local_bus_cfg.svh"
interface rx_segmented_local_bus_if #(parameter int LANES = 10);
    localparam int CW = LANES;
    localparam int PW = (LANES == 10) ? 3 : 1;
    logic [`SEGS-1:0] rx_seg_valid;
    logic [`SEGS-1:0][`SEG_W-1:0] rx_seg_data;
    logic [`SEGS-1:0] rx_seg_first;
    logic [`SEGS-1:0] rx_seg_last;
    logic [`SEGS-1:0] rx_seg_bad;
    logic [`SEGS-1:0][`EMPTY_W-1:0] rx_seg_empty_bytes;
    logic tx_reset_done;
    logic rx_reset_done;
    logic [`SERDES_LANES-1:0] rx_serdes_reset_done;
    logic tx_reset_done_sync;
    logic rx_reset_done_sync;
    logic xcvr_tx_rst_complete;
    logic xcvr_rx_rst_complete;
    logic usr_tx_rst;
    logic usr_rx_rst;
    logic [`SERDES_LANES-1:0] usr_rx_serdes_rst;
    logic regmap_xcvr_full_rst;
    logic regmap_xcvr_loopback;
    logic [`SERDES_LANES-1:0] rx_serdes_clk;
    logic [`SERDES_LANES-1:0] rx_serdes_clk_in;
    logic [CW-1:0] pll_a_clk;
    logic [CW-1:0] pll_a_ref_clk;
    logic [CW-1:0] pll_b_clk;
    logic [CW-1:0] pll_b_ref_clk;
    logic [PW-1:0] pll_a_lock_in;
    logic [PW-1:0] pll_a_rst_out;
    logic [PW-1:0] pll_b_lock_in;
    logic [PW-1:0] pll_b_rst_out;
    modport dev (
        output rx_seg_valid, rx_seg_data, rx_seg_first, rx_seg_last,
        output rx_seg_bad, rx_seg_empty_bytes,
        output xcvr_tx_rst_complete, xcvr_rx_rst_complete,
        output usr_tx_rst, usr_rx_rst, usr_rx_serdes_rst,
        output regmap_xcvr_full_rst, regmap_xcvr_loopback,
        output rx_serdes_clk, pll_a_rst_out, pll_b_rst_out,
        input tx_reset_done, rx_reset_done, rx_serdes_reset_done,
        input tx_reset_done_sync, rx_reset_done_sync, rx_serdes_clk_in,
        input pll_a_clk, pll_a_ref_clk, pll_b_clk, pll_b_ref_clk,
        input pll_a_lock_in, pll_b_lock_in
    );
    modport usr (
        input rx_seg_valid, rx_seg_data, rx_seg_first, rx_seg_last,
        input rx_seg_bad, rx_seg_empty_bytes,
        input xcvr_tx_rst_complete, xcvr_rx_rst_complete,
        input usr_tx_rst, usr_rx_rst, usr_rx_serdes_rst,
        input regmap_xcvr_full_rst, regmap_xcvr_loopback,
        input rx_serdes_clk, pll_a_rst_out, pll_b_rst_out,
        output tx_reset_done, rx_reset_done, rx_serdes_reset_done,
        output tx_reset_done_sync, rx_reset_done_sync, rx_serdes_clk_in,
        output pll_a_clk, pll_a_ref_clk, pll_b_clk, pll_b_ref_clk,
        output pll_a_lock_in, pll_b_lock_in
    );
endinterface : rx_segmented_local_bus_if

/* File: verilog/rx_segmented_local_bus_user.sv */
// user end: reset wrapper handshakes and packet sink of the receive bus
`timescale 1ns/100ps
`include "segmented_local_bus_cfg.svh"
module rx_segmented_local_bus_user
    import segmented_local_bus_pkg::*;
#(
    parameter int LANES = 10
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wrap_tx_done,
    input wire logic wrap_rx_done,
    input wire logic [`SERDES_LANES-1:0] wrap_serdes_done,
    input wire logic [`SERDES_LANES-1:0] ext_serdes_clk,
    input wire logic [LANES-1:0] ext_pll_a_clk,
    input wire logic [LANES-1:0] ext_pll_a_ref_clk,
    input wire logic [LANES-1:0] ext_pll_b_clk,
    input wire logic [LANES-1:0] ext_pll_b_ref_clk,
    input wire logic [2:0] ext_pll_a_lock,
    input wire logic [2:0] ext_pll_b_lock,
    output logic [2:0] pkt_ends,
    output logic [2:0] pkt_bad_ends,
    output logic [15:0] pkt_last_len,
    output logic framing_err,
    output logic [3:0] rst_req,
    output logic [`SERDES_LANES-1:0] serdes_rst_req,
    rx_segmented_local_bus_if.usr bus
);
    localparam int PW = (LANES == 10) ? 3 : 1;

    if (!(LANES == 10 || LANES == 4))
    begin : bad_cfg
        $error("rx_segmented_local_bus_user: LANES must be 10 or 4");
    end

    usr_state_t s;
    usr_state_t next_s;

    // packet walk in ascending segment order
    always_comb
    begin
        next_s = s;
        next_s.w1 = {wrap_serdes_done, wrap_rx_done, wrap_tx_done, 3'h0};
        next_s.w2 = s.w1;
        next_s.w3 = s.w2[4:3];
        next_s.ends = 3'h0;
        next_s.bad_ends = 3'h0;
        next_s.rst_req = {bus.regmap_xcvr_loopback, bus.regmap_xcvr_full_rst,
                          bus.usr_rx_rst, bus.usr_tx_rst};
        next_s.serdes_rst_req = bus.usr_rx_serdes_rst;
        for (int i = 0; i < `SEGS; i++)
        begin
            // disabled segments are ignored entirely
            if (bus.rx_seg_valid[i])
            begin
                if (bus.rx_seg_first[i])
                begin
                    next_s.framing_err = next_s.framing_err
                        || next_s.phase == PH_IN_PKT;
                    next_s.len = 16'h0;
                    next_s.phase = PH_IN_PKT;
                end
                else if (next_s.phase == PH_IDLE)
                    next_s.framing_err = 1'b1;
                if (bus.rx_seg_last[i])
                begin
                    next_s.len = next_s.len + {11'h0, `SEG_BYTES
                        - {1'b0, bus.rx_seg_empty_bytes[i]}};
                    next_s.last_len = next_s.len;
                    next_s.ends = next_s.ends + 3'h1;
                    next_s.bad_ends = next_s.bad_ends
                        + {2'h0, bus.rx_seg_bad[i]};
                    next_s.phase = PH_IDLE;
                end
                else
                    next_s.len = next_s.len + {11'h0, `SEG_BYTES};
            end
        end
        case (s.phase)
            PH_IDLE, PH_IN_PKT: next_s.phase = next_s.phase;
            default: next_s.phase = PH_IDLE;
        endcase
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign pkt_ends = s.ends;
    assign pkt_bad_ends = s.bad_ends;
    assign pkt_last_len = s.last_len;
    assign framing_err = s.framing_err;
    assign rst_req = s.rst_req;
    assign serdes_rst_req = s.serdes_rst_req;
    // done bits after two flops; sync copies one stage later
    assign bus.tx_reset_done = s.w2[3];
    assign bus.rx_reset_done = s.w2[4];
    assign bus.rx_serdes_reset_done = s.w2[`SERDES_LANES+4:5];
    assign bus.tx_reset_done_sync = s.w3[0];
    assign bus.rx_reset_done_sync = s.w3[1];
    // clocks pass straight through; they are not sampled here
    assign bus.rx_serdes_clk_in = ext_serdes_clk;
    assign bus.pll_a_clk = ext_pll_a_clk;
    assign bus.pll_a_ref_clk = ext_pll_a_ref_clk;
    assign bus.pll_b_clk = ext_pll_b_clk;
    assign bus.pll_b_ref_clk = ext_pll_b_ref_clk;
    assign bus.pll_a_lock_in = ext_pll_a_lock[PW-1:0];
    assign bus.pll_b_lock_in = ext_pll_b_lock[PW-1:0];
endmodule : rx_segmented_local_bus_user

/* File: verilog/segmented_local_bus_cfg.svh */
// offsets, field positions, reset values and sizes of the receive bus pair
`ifndef SEGMENTED_LOCAL_BUS_CFG_SVH
`define SEGMENTED_LOCAL_BUS_CFG_SVH
`define SEGS 4
`define SEG_W 128
`define EMPTY_W 4
`define SEG_BYTES 5'h10
`define SERDES_LANES 10
`define APB_AW 8
`define REG_CTRL 8'h00
`define REG_SERDES_RST 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STAT 8'h0c
`define REG_IRQ_MASK 8'h10
`define REG_PKT_COUNT 8'h14
`define CTRL_TX_RST 0
`define CTRL_RX_RST 1
`define CTRL_FULL_RST 2
`define CTRL_LOOPBACK 3
`define IRQ_PKT_END 0
`define IRQ_PKT_BAD 1
`define IRQ_RX_READY 2
`define CTRL_RESET 4'h0
`define SERDES_RST_RESET 10'h000
`define IRQ_MASK_RESET 3'h0
`endif

/* File: verilog/segmented_local_bus_pkg.sv */
// types of the core end and the user end of the receive bus, each state type used by one end only
`include "segmented_local_bus_cfg.svh"
package segmented_local_bus_pkg;
    typedef logic [`SEGS-1:0][`SEG_W-1:0] seg_data_t;
    typedef logic [`SEGS-1:0][`EMPTY_W-1:0] seg_empty_t;
    // pin group that crosses into the core through two flops
    typedef struct packed {
        logic [1:0] xcvr;
        logic [2:0] lock;
        logic [`SERDES_LANES-1:0] serdes;
        logic [3:0] done;
    } pinset_t;
    typedef struct packed {
        pinset_t s1;
        pinset_t s2;
        logic [3:0] ctrl;
        logic [`SERDES_LANES-1:0] serdes_rst;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] pkt_count;
        logic ready_prev;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
        logic [`SEGS-1:0] valid;
        seg_data_t data;
        logic [`SEGS-1:0] first;
        logic [`SEGS-1:0] last;
        logic [`SEGS-1:0] bad;
        seg_empty_t empty;
        logic xcvr_tx;
        logic xcvr_rx;
        logic [`SERDES_LANES-1:0] lane_clk;
    } core_state_t;
    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_IN_PKT = 1'b1
    } usr_phase_t;
    typedef struct packed {
        logic [`SERDES_LANES+4:0] w1;
        logic [`SERDES_LANES+4:0] w2;
        logic [1:0] w3;
        usr_phase_t phase;
        logic [15:0] len;
        logic [15:0] last_len;
        logic [2:0] ends;
        logic [2:0] bad_ends;
        logic framing_err;
        logic [3:0] rst_req;
        logic [`SERDES_LANES-1:0] serdes_rst_req;
    } usr_state_t;
endpackage : segmented_local_bus_pkg
